// file: design/jtdbg_pkg.sv
// constants and types shared by the test and debug port
package jtdbg_pkg;
  // ===========================================================
  // instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_DBG0 = 4'h8; // mailbox readout
  localparam logic [3:0] IR_DBG1 = 4'h9; // breakpoint address load
  localparam logic [3:0] IR_DBG2 = 4'ha; // cpu instruction feed
  localparam logic [3:0] IR_DBG3 = 4'hb; // debug control
  localparam logic [3:0] IR_PRST = 4'hc;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1; // captured ir pattern
  // ===========================================================
  // identification word, all values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  // ===========================================================
  // data register widths
  localparam int PINS = 8;
  localparam int BSR_W = 3 * PINS;
  localparam int BPA_W = 18; // 16 address bits, 2 slot bits
  localparam int CTL_W = 7;
  // debug control field positions
  localparam int CTL_MBX_EN = 0;
  localparam int CTL_FLOW = 1;
  localparam int CTL_STEP = 2;
  localparam int CTL_MODE_LO = 3; // two bits
  localparam int CTL_RNG_DATA = 5;
  localparam int CTL_BP_EN = 6;
  localparam logic [6:0] CTL_RST = 7'h00;
  // breakpoint layouts
  localparam logic [1:0] BP_4P = 2'h0;
  localparam logic [1:0] BP_3P1D = 2'h1;
  localparam logic [1:0] BP_2P2D = 2'h2;
  localparam logic [1:0] BP_RANGE = 2'h3;
  // ===========================================================
  // tap controller states
  typedef enum logic [3:0] {
    S_EX2D = 4'h0, S_EX1D = 4'h1, S_SHD = 4'h2, S_PAD = 4'h3,
    S_IDLE = 4'h4, S_UPD = 4'h5, S_CAPD = 4'h6, S_SELD = 4'h7,
    S_EX2I = 4'h8, S_EX1I = 4'h9, S_SHI = 4'ha, S_PAI = 4'hb,
    S_TLR = 4'hc, S_UPI = 4'hd, S_CAPI = 4'he, S_SELI = 4'hf
  } jtdbg_tap_t;
endpackage : jtdbg_pkg

// file: design/jtdbg_top.sv
// test access port, on-chip debug and boundary-scan logic
`timescale 1ns/10ps
`default_nettype none
module jtdbg_top (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_TCK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  output logic O_TDO,
  output logic O_TDO_OE_N,
  input wire logic I_TEST_PORT_FUSE,
  input wire logic I_DEBUG_ENABLE_FUSE,
  input wire logic I_LOCK_BIT_ONE,
  input wire logic I_LOCK_BIT_TWO,
  input wire logic I_CHIP_ERASE_DONE,
  output logic O_DEBUG_FUSE_PGM_OK,
  input wire logic I_CSR_WR,
  input wire logic I_CSR_DISABLE,
  output logic O_TEST_PORT_DISABLE_BIT,
  input wire logic I_MBX_WR,
  input wire logic [7:0] I_MBX_WDATA,
  output logic [7:0] O_MBX_RDATA,
  output logic O_MBX_SEL,
  output logic [15:0] O_CPU_INSTR,
  output logic O_CPU_INSTR_STB,
  input wire logic [15:0] I_PC,
  input wire logic I_PC_VLD,
  input wire logic I_FLOW_CHANGE,
  input wire logic [15:0] I_DATA_ADDR,
  input wire logic I_DATA_VLD,
  output logic O_BREAK,
  input wire logic I_EXT_RST_N,
  output logic O_CPU_RST,
  input wire logic [7:0] I_CORE_OUT,
  input wire logic [7:0] I_CORE_OE,
  input wire logic [7:0] I_PIN_IN,
  output logic [7:0] O_PIN_OUT,
  output logic [7:0] O_PIN_OE_N
);
  localparam int P = jtdbg_pkg::PINS;
  localparam int BW = jtdbg_pkg::BSR_W;
  localparam int CW = jtdbg_pkg::CTL_W;
  // ===========================================================
  // reference clock domain: cpu side registers
  logic disable_ff, en_ff, dbg_ok_ff, mbx_dirty_ff, mbx_dirty_nx;
  logic [7:0] mbx_byte_ff;
  logic [2:0] clr_sync_ff, bpa_sync_ff, ins_sync_ff;
  logic [1:0] rst_sync_ff, extrst_sync_ff;
  logic [CW-1:0] ctl_r_ff;
  logic [1:0] ctl_sync_ff [CW];
  logic [15:0] bp_addr_ff [4];
  logic [2:0] bp_hit;
  // ===========================================================
  // tck domain
  jtdbg_pkg::jtdbg_tap_t tap_ff, nxt_tap;
  logic [1:0] en_sync_ff, dbg_sync_ff, dirty_sync_ff;
  logic [P-1:0] pin_s1_ff, pin_s2_ff;
  logic [3:0] ir_sh_ff, ir_ff;
  logic byp_ff, rst_reg_ff, tdo_ff, tdo_oe_n_ff;
  logic [31:0] id_sh_ff;
  logic [BW-1:0] bsr_sh_ff, bsr_lat_ff;
  logic [7:0] mbx_sh_ff;
  logic [jtdbg_pkg::BPA_W-1:0] bpa_sh_ff, bpa_ff;
  logic [15:0] ins_sh_ff, ins_ff;
  logic [CW-1:0] ctl_sh_ff, ctl_ff;
  logic clr_tgl_ff, bpa_tgl_ff, ins_tgl_ff, extest_ff, tdo_nx;
  logic tap_en, dbg_en, dbg_ir;
  logic [1:0] bp_mode;

  // shared address comparison, optionally masked
  function automatic logic addr_eq(input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] m);
    addr_eq = ((a ^ b) & m) == 16'h0000;
  endfunction : addr_eq

  // ===========================================================
  // test port and debug gating, cpu control bit
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      disable_ff <= 1'b0;
      en_ff <= 1'b0;
      dbg_ok_ff <= 1'b0;
      O_DEBUG_FUSE_PGM_OK <= 1'b0;
      O_TEST_PORT_DISABLE_BIT <= 1'b0;
    end else begin
      if (I_CSR_WR) begin
        disable_ff <= I_CSR_DISABLE;
      end
      O_TEST_PORT_DISABLE_BIT <= disable_ff;
      en_ff <= I_TEST_PORT_FUSE & ~disable_ff;
      dbg_ok_ff <= I_TEST_PORT_FUSE & I_DEBUG_ENABLE_FUSE &
          ~(I_LOCK_BIT_ONE | I_LOCK_BIT_TWO);
      // lock bits gate fuse writes as in parallel mode
      O_DEBUG_FUSE_PGM_OK <= ~(I_LOCK_BIT_ONE | I_LOCK_BIT_TWO) |
          I_CHIP_ERASE_DONE;
    end
  end

  // ===========================================================
  // crossings from tck and the reset pin into the reference domain
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      clr_sync_ff <= 3'h0;
      bpa_sync_ff <= 3'h0;
      ins_sync_ff <= 3'h0;
      rst_sync_ff <= 2'h0;
      extrst_sync_ff <= 2'h3;
      for (int i = 0; i < CW; i++) begin
        ctl_sync_ff[i] <= 2'h0;
      end
    end else begin
      clr_sync_ff <= {clr_sync_ff[1:0], clr_tgl_ff};
      bpa_sync_ff <= {bpa_sync_ff[1:0], bpa_tgl_ff};
      ins_sync_ff <= {ins_sync_ff[1:0], ins_tgl_ff};
      rst_sync_ff <= {rst_sync_ff[0], rst_reg_ff};
      extrst_sync_ff <= {extrst_sync_ff[0], I_EXT_RST_N};
      for (int i = 0; i < CW; i++) begin
        ctl_sync_ff[i] <= {ctl_sync_ff[i][0], ctl_ff[i]};
      end
    end
  end

  // settled debug control word
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctl_r_ff <= jtdbg_pkg::CTL_RST;
    end else begin
      for (int i = 0; i < CW; i++) begin
        ctl_r_ff[i] <= ctl_sync_ff[i][1] & dbg_ok_ff;
      end
    end
  end

  // ===========================================================
  // reset sources and cpu reset output
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CPU_RST <= 1'b1;
    end else begin
      O_CPU_RST <= ~extrst_sync_ff[1] | rst_sync_ff[1];
    end
  end

  // ===========================================================
  // mailbox: byte store, dirty flag, shared address select
  always_comb begin
    mbx_dirty_nx = mbx_dirty_ff;
    if (clr_sync_ff[2] ^ clr_sync_ff[1]) begin
      mbx_dirty_nx = 1'b0;
    end
    if (I_MBX_WR && O_MBX_SEL) begin
      mbx_dirty_nx = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mbx_byte_ff <= 8'h00;
      mbx_dirty_ff <= 1'b0;
      O_MBX_SEL <= 1'b0;
      O_MBX_RDATA <= 8'h00;
    end else begin
      if (I_MBX_WR && O_MBX_SEL) begin
        mbx_byte_ff <= I_MBX_WDATA;
      end
      mbx_dirty_ff <= mbx_dirty_nx;
      O_MBX_SEL <= I_DEBUG_ENABLE_FUSE &
          ctl_r_ff[jtdbg_pkg::CTL_MBX_EN];
      // new byte shows together with its dirty flag
      O_MBX_RDATA <= {mbx_dirty_nx, (I_MBX_WR && O_MBX_SEL) ?
          I_MBX_WDATA[6:0] : mbx_byte_ff[6:0]};
    end
  end

  // ===========================================================
  // instruction feed into the cpu
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CPU_INSTR <= 16'h0000;
      O_CPU_INSTR_STB <= 1'b0;
    end else begin
      O_CPU_INSTR_STB <= 1'b0;
      if ((ins_sync_ff[2] ^ ins_sync_ff[1]) && dbg_ok_ff) begin
        O_CPU_INSTR <= ins_ff;
        O_CPU_INSTR_STB <= 1'b1;
      end
    end
  end

  // ===========================================================
  // breakpoint unit
  assign bp_mode = ctl_r_ff[jtdbg_pkg::CTL_MODE_LO +: 2];

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < 4; i++) begin
        bp_addr_ff[i] <= 16'h0000;
      end
    end else if (bpa_sync_ff[2] ^ bpa_sync_ff[1]) begin
      bp_addr_ff[bpa_ff[17:16]] <= bpa_ff[15:0];
    end
  end

  // slot 0 and 1 always program; 2 and 3 follow the layout
  always_comb begin
    bp_hit[0] = I_PC_VLD &
        (addr_eq(I_PC, bp_addr_ff[0], 16'hffff) |
         addr_eq(I_PC, bp_addr_ff[1], 16'hffff));
    bp_hit[1] = 1'b0;
    bp_hit[2] = 1'b0;
    unique case (bp_mode)
      jtdbg_pkg::BP_4P: begin
        bp_hit[1] = I_PC_VLD &
            (addr_eq(I_PC, bp_addr_ff[2], 16'hffff) |
             addr_eq(I_PC, bp_addr_ff[3], 16'hffff));
      end
      jtdbg_pkg::BP_3P1D: begin
        bp_hit[1] = I_PC_VLD &
            addr_eq(I_PC, bp_addr_ff[2], 16'hffff);
        bp_hit[2] = I_DATA_VLD &
            addr_eq(I_DATA_ADDR, bp_addr_ff[3], 16'hffff);
      end
      jtdbg_pkg::BP_2P2D: begin
        bp_hit[2] = I_DATA_VLD &
            (addr_eq(I_DATA_ADDR, bp_addr_ff[2], 16'hffff) |
             addr_eq(I_DATA_ADDR, bp_addr_ff[3], 16'hffff));
      end
      jtdbg_pkg::BP_RANGE: begin
        // slot 3 is the mask of slot 2
        if (ctl_r_ff[jtdbg_pkg::CTL_RNG_DATA]) begin
          bp_hit[2] = I_DATA_VLD &
              addr_eq(I_DATA_ADDR, bp_addr_ff[2], bp_addr_ff[3]);
        end else begin
          bp_hit[1] = I_PC_VLD &
              addr_eq(I_PC, bp_addr_ff[2], bp_addr_ff[3]);
        end
      end
    endcase
  end

  // break request to the cpu
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_BREAK <= 1'b0;
    end else begin
      O_BREAK <= (ctl_r_ff[jtdbg_pkg::CTL_BP_EN] & (|bp_hit)) |
          (ctl_r_ff[jtdbg_pkg::CTL_FLOW] & I_FLOW_CHANGE) |
          (ctl_r_ff[jtdbg_pkg::CTL_STEP] & I_PC_VLD);
    end
  end

  // ===========================================================
  // tck domain: level crossings and pin synchronisers
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      en_sync_ff <= 2'h0;
      dbg_sync_ff <= 2'h0;
      dirty_sync_ff <= 2'h0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      en_sync_ff <= {en_sync_ff[0], en_ff};
      dbg_sync_ff <= {dbg_sync_ff[0], dbg_ok_ff};
      dirty_sync_ff <= {dirty_sync_ff[0], mbx_dirty_ff};
      pin_s1_ff <= I_PIN_IN;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign tap_en = en_sync_ff[1];
  assign dbg_en = dbg_sync_ff[1];
  assign dbg_ir = dbg_en && (ir_ff[3:2] == 2'b10);

  // ===========================================================
  // tap state sequencing
  always_comb begin
    nxt_tap = tap_ff;
    unique case (tap_ff)
      jtdbg_pkg::S_TLR: nxt_tap = I_TMS ? jtdbg_pkg::S_TLR : jtdbg_pkg::S_IDLE;
      jtdbg_pkg::S_IDLE: nxt_tap = I_TMS ? jtdbg_pkg::S_SELD : jtdbg_pkg::S_IDLE;
      jtdbg_pkg::S_SELD: nxt_tap = I_TMS ? jtdbg_pkg::S_SELI : jtdbg_pkg::S_CAPD;
      jtdbg_pkg::S_CAPD: nxt_tap = I_TMS ? jtdbg_pkg::S_EX1D : jtdbg_pkg::S_SHD;
      jtdbg_pkg::S_SHD: nxt_tap = I_TMS ? jtdbg_pkg::S_EX1D : jtdbg_pkg::S_SHD;
      jtdbg_pkg::S_EX1D: nxt_tap = I_TMS ? jtdbg_pkg::S_UPD : jtdbg_pkg::S_PAD;
      jtdbg_pkg::S_PAD: nxt_tap = I_TMS ? jtdbg_pkg::S_EX2D : jtdbg_pkg::S_PAD;
      jtdbg_pkg::S_EX2D: nxt_tap = I_TMS ? jtdbg_pkg::S_UPD : jtdbg_pkg::S_SHD;
      jtdbg_pkg::S_UPD: nxt_tap = I_TMS ? jtdbg_pkg::S_SELD : jtdbg_pkg::S_IDLE;
      jtdbg_pkg::S_SELI: nxt_tap = I_TMS ? jtdbg_pkg::S_TLR : jtdbg_pkg::S_CAPI;
      jtdbg_pkg::S_CAPI: nxt_tap = I_TMS ? jtdbg_pkg::S_EX1I : jtdbg_pkg::S_SHI;
      jtdbg_pkg::S_SHI: nxt_tap = I_TMS ? jtdbg_pkg::S_EX1I : jtdbg_pkg::S_SHI;
      jtdbg_pkg::S_EX1I: nxt_tap = I_TMS ? jtdbg_pkg::S_UPI : jtdbg_pkg::S_PAI;
      jtdbg_pkg::S_PAI: nxt_tap = I_TMS ? jtdbg_pkg::S_EX2I : jtdbg_pkg::S_PAI;
      jtdbg_pkg::S_EX2I: nxt_tap = I_TMS ? jtdbg_pkg::S_UPI : jtdbg_pkg::S_SHI;
      jtdbg_pkg::S_UPI: nxt_tap = I_TMS ? jtdbg_pkg::S_SELD : jtdbg_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tap_ff <= jtdbg_pkg::S_TLR;
    end else if (!tap_en) begin
      tap_ff <= jtdbg_pkg::S_TLR;
    end else begin
      tap_ff <= nxt_tap;
    end
  end

  // ===========================================================
  // instruction register
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ir_sh_ff <= jtdbg_pkg::IR_CAPTURE;
      ir_ff <= jtdbg_pkg::IR_IDCODE;
    end else if (tap_ff == jtdbg_pkg::S_TLR) begin
      ir_ff <= jtdbg_pkg::IR_IDCODE;
    end else if (tap_ff == jtdbg_pkg::S_CAPI) begin
      ir_sh_ff <= jtdbg_pkg::IR_CAPTURE;
    end else if (tap_ff == jtdbg_pkg::S_SHI) begin
      ir_sh_ff <= {I_TDI, ir_sh_ff[3:1]};
    end else if (tap_ff == jtdbg_pkg::S_UPI) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // ===========================================================
  // public data registers: bypass, id, reset, boundary chain
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      byp_ff <= 1'b0;
      id_sh_ff <= 32'h0000_0000;
      rst_reg_ff <= 1'b0;
      bsr_sh_ff <= '0;
    end else if (tap_ff == jtdbg_pkg::S_CAPD) begin
      byp_ff <= 1'b0;
      id_sh_ff <= {jtdbg_pkg::ID_VERSION, jtdbg_pkg::ID_PART,
          jtdbg_pkg::ID_MAKER, 1'b1};
      if (ir_ff == jtdbg_pkg::IR_EXTEST || ir_ff == jtdbg_pkg::IR_SAMPLE) begin
        bsr_sh_ff <= {I_CORE_OE, I_CORE_OUT, pin_s2_ff};
      end
    end else if (tap_ff == jtdbg_pkg::S_SHD) begin
      // all chains move lsb first
      byp_ff <= I_TDI;
      id_sh_ff <= {I_TDI, id_sh_ff[31:1]};
      if (ir_ff == jtdbg_pkg::IR_PRST) begin
        rst_reg_ff <= I_TDI;
      end
      bsr_sh_ff <= {I_TDI, bsr_sh_ff[BW-1:1]};
    end
  end

  // boundary output latches and extest select
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bsr_lat_ff <= '0;
      extest_ff <= 1'b0;
    end else begin
      if (tap_ff == jtdbg_pkg::S_UPD && (ir_ff == jtdbg_pkg::IR_EXTEST ||
          ir_ff == jtdbg_pkg::IR_SAMPLE)) begin
        bsr_lat_ff <= bsr_sh_ff;
      end
      extest_ff <= (nxt_tap == jtdbg_pkg::S_IDLE ||
          tap_ff != jtdbg_pkg::S_TLR) && tap_en &&
          ((tap_ff == jtdbg_pkg::S_UPI) ? ir_sh_ff == jtdbg_pkg::IR_EXTEST :
          ir_ff == jtdbg_pkg::IR_EXTEST);
    end
  end

  // pins: latches under extest, high impedance in reset, else core
  always_comb begin
    for (int i = 0; i < P; i++) begin
      if (extest_ff) begin
        O_PIN_OUT[i] = bsr_lat_ff[P + i];
        O_PIN_OE_N[i] = ~bsr_lat_ff[2*P + i];
      end else begin
        O_PIN_OUT[i] = I_CORE_OUT[i];
        O_PIN_OE_N[i] = O_CPU_RST | rst_reg_ff | ~I_CORE_OE[i];
      end
    end
  end

  // ===========================================================
  // debug data registers
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mbx_sh_ff <= 8'h00;
      bpa_sh_ff <= '0;
      ins_sh_ff <= 16'h0000;
      ctl_sh_ff <= jtdbg_pkg::CTL_RST;
    end else if (tap_ff == jtdbg_pkg::S_CAPD) begin
      mbx_sh_ff <= dirty_sync_ff[1] ? mbx_byte_ff : 8'h00;
      ctl_sh_ff <= ctl_ff;
    end else if (tap_ff == jtdbg_pkg::S_SHD) begin
      mbx_sh_ff <= {I_TDI, mbx_sh_ff[7:1]};
      bpa_sh_ff <= {I_TDI, bpa_sh_ff[jtdbg_pkg::BPA_W-1:1]};
      ins_sh_ff <= {I_TDI, ins_sh_ff[15:1]};
      ctl_sh_ff <= {I_TDI, ctl_sh_ff[CW-1:1]};
    end
  end

  // update of debug registers and event toggles
  always_ff @(posedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bpa_ff <= '0;
      ins_ff <= 16'h0000;
      ctl_ff <= jtdbg_pkg::CTL_RST;
      clr_tgl_ff <= 1'b0;
      bpa_tgl_ff <= 1'b0;
      ins_tgl_ff <= 1'b0;
    end else if (!dbg_en) begin
      ctl_ff <= jtdbg_pkg::CTL_RST;
    end else if (tap_ff == jtdbg_pkg::S_UPD) begin
      unique case (ir_ff)
        jtdbg_pkg::IR_DBG0: clr_tgl_ff <= ~clr_tgl_ff;
        jtdbg_pkg::IR_DBG1: begin
          bpa_ff <= bpa_sh_ff;
          bpa_tgl_ff <= ~bpa_tgl_ff;
        end
        jtdbg_pkg::IR_DBG2: begin
          ins_ff <= ins_sh_ff;
          ins_tgl_ff <= ~ins_tgl_ff;
        end
        jtdbg_pkg::IR_DBG3: ctl_ff <= ctl_sh_ff;
        default: begin
        end
      endcase
    end
  end

  // ===========================================================
  // tdo path, driven on the falling edge while shifting
  always_comb begin
    tdo_nx = byp_ff;
    if (tap_ff == jtdbg_pkg::S_SHI) begin
      tdo_nx = ir_sh_ff[0];
    end else if (dbg_ir) begin
      unique case (ir_ff[1:0])
        2'h0: tdo_nx = mbx_sh_ff[0];
        2'h1: tdo_nx = bpa_sh_ff[0];
        2'h2: tdo_nx = ins_sh_ff[0];
        2'h3: tdo_nx = ctl_sh_ff[0];
      endcase
    end else if (ir_ff == jtdbg_pkg::IR_IDCODE) begin
      tdo_nx = id_sh_ff[0];
    end else if (ir_ff == jtdbg_pkg::IR_PRST) begin
      tdo_nx = rst_reg_ff;
    end else if (ir_ff == jtdbg_pkg::IR_EXTEST ||
        ir_ff == jtdbg_pkg::IR_SAMPLE) begin
      tdo_nx = bsr_sh_ff[0];
    end
  end

  always_ff @(negedge I_TCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tdo_ff <= 1'b0;
      tdo_oe_n_ff <= 1'b1;
    end else begin
      tdo_ff <= tdo_nx;
      tdo_oe_n_ff <= ~(tap_ff == jtdbg_pkg::S_SHD ||
          tap_ff == jtdbg_pkg::S_SHI);
    end
  end

  assign O_TDO = tdo_ff;
  assign O_TDO_OE_N = tdo_oe_n_ff;
endmodule : jtdbg_top
`default_nettype wire

// file: verif/jtag_debug_and_boundary_scan_tb_top.sv
// self-checking bench for the test and debug port
`timescale 1ns/10ps
`default_nettype none
module jtag_debug_and_boundary_scan_tb_top;
  logic clk = 1'b0, rst = 1'b1, fd = 1'b1, l1 = 1'b0, er = 1'b0, b;
  logic cw = 1'b0, cd = 1'b0, mw = 1'b0, fl = 1'b0, pcv = 1'b0, ern = 1'b1;
  logic l2 = 1'b0;
  logic [7:0] md = 8'h00, coe = 8'h00, pin = 8'h00, mrd, pout, poe;
  logic [15:0] ins;
  logic [31:0] r;
  logic tck, tms, tdi, tdo, tdoe, pok, dis, msel, stb, brk, crst;
  int n_fail = 0, checks = 0, cyc = 0;
  jtdbg_top dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_TCK(tck),
    .I_TMS(tms), .I_TDI(tdi), .O_TDO(tdo), .O_TDO_OE_N(tdoe),
    .I_TEST_PORT_FUSE(1'b1), .I_DEBUG_ENABLE_FUSE(fd), .I_LOCK_BIT_ONE(l1),
    .I_LOCK_BIT_TWO(l2), .I_CHIP_ERASE_DONE(er), .O_DEBUG_FUSE_PGM_OK(pok),
    .I_CSR_WR(cw), .I_CSR_DISABLE(cd), .O_TEST_PORT_DISABLE_BIT(dis),
    .I_MBX_WR(mw), .I_MBX_WDATA(md), .O_MBX_RDATA(mrd), .O_MBX_SEL(msel),
    .O_CPU_INSTR(ins), .O_CPU_INSTR_STB(stb), .I_PC(16'h0000),
    .I_PC_VLD(pcv), .I_FLOW_CHANGE(fl), .I_DATA_ADDR(16'h0000),
    .I_DATA_VLD(1'b0), .O_BREAK(brk), .I_EXT_RST_N(ern), .O_CPU_RST(crst),
    .I_CORE_OUT(8'h00), .I_CORE_OE(coe), .I_PIN_IN(pin), .O_PIN_OUT(pout),
    .O_PIN_OE_N(poe));
  jtdbg_jtag_bfm bfm (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
    .i_tdo_oe_n(tdoe));
  // clock and cycle ceiling
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ======
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic sc(input logic ir, input int n, input logic [31:0] d);
    bfm.scan(ir, n, d, r);
  endtask : sc
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic idle4;
    repeat (4) bfm.tick(1'b1, 1'b0, b);
  endtask : idle4
  task automatic chk_id;
    sc(1'b0, 32, 32'h0);
    chk(r, {jtdbg_pkg::ID_VERSION, jtdbg_pkg::ID_PART, jtdbg_pkg::ID_MAKER,
      1'b1});
  endtask : chk_id
  task automatic csr(input logic v);
    w(1);
    cd = v;
    cw = 1'b1;
    w(1);
    cw = 1'b0;
    w(4);
    chk(dis, v);
  endtask : csr
  // ======
  // scenarios
  task automatic t_byp;
    sc(1'b1, 4, jtdbg_pkg::IR_BYPASS);
    chk(r[3:0], jtdbg_pkg::IR_CAPTURE);
    sc(1'b0, 3, 32'h3);
    chk(r[2:0], 3'h6);
    $display("t_byp done");
  endtask : t_byp
  task automatic t_mbx;
    chk(mrd[7], 1'b0);
    sc(1'b1, 4, jtdbg_pkg::IR_DBG3);
    sc(1'b0, 7, 32'h1);
    w(8);
    chk(msel, 1'b1);
    md = 8'h45;
    mw = 1'b1;
    w(1);
    mw = 1'b0;
    chk(mrd, 8'hc5);
    sc(1'b1, 4, jtdbg_pkg::IR_DBG0);
    sc(1'b0, 8, 32'h0);
    chk(r[7:0], 8'h45);
    w(6);
    chk(mrd, 8'h45);
    sc(1'b1, 4, jtdbg_pkg::IR_DBG2);
    sc(1'b0, 16, 32'h1234);
    w(6);
    chk(ins, 16'h1234);
    fd = 1'b0;
    w(3);
    chk(msel, 1'b0);
    fd = 1'b1;
    $display("t_mbx done");
  endtask : t_mbx
  task automatic t_bp;
    sc(1'b1, 4, jtdbg_pkg::IR_DBG3);
    sc(1'b0, 7, 32'h43);
    w(4);
    fl = 1'b1;
    pcv = 1'b1;
    w(2);
    chk(brk, 1'b1);
    fl = 1'b0;
    l1 = 1'b1;
    w(8);
    fl = 1'b1;
    w(2);
    chk({brk, pok}, 2'h0);
    er = 1'b1;
    w(2);
    chk(pok, 1'b1);
    // second lock bit alone must gate debug and fuse writes too
    {l1, l2, er} = 3'h2;
    w(8);
    chk({brk, pok}, 2'h0);
    {fl, pcv, l1, er} = 4'h0;
    l2 = 1'b0;
    $display("t_bp done");
  endtask : t_bp
  task automatic t_bs;
    pin = 8'ha5;
    sc(1'b1, 4, jtdbg_pkg::IR_SAMPLE);
    sc(1'b0, 24, 32'hff3c00);
    chk({poe, r[7:0]}, 16'hffa5);
    sc(1'b1, 4, jtdbg_pkg::IR_EXTEST);
    chk({poe, pout}, 16'h003c);
    sc(1'b1, 4, jtdbg_pkg::IR_BYPASS);
    $display("t_bs done");
  endtask : t_bs
  task automatic t_rst;
    w(1);
    coe = 8'hff;
    sc(1'b1, 4, jtdbg_pkg::IR_PRST);
    sc(1'b0, 1, 32'h1);
    w(4);
    chk({crst, poe}, 9'h1ff);
    sc(1'b0, 1, 32'h0);
    w(5);
    chk({crst, poe}, 9'h000);
    ern = 1'b0;
    w(6);
    chk(crst, 1'b1);
    ern = 1'b1;
    w(6);
    chk(crst, 1'b0);
    $display("t_rst done");
  endtask : t_rst
  task automatic t_dis;
    csr(1'b1);
    idle4();
    sc(1'b0, 32, 32'h0);
    chk(r, 32'hffffffff);
    csr(1'b0);
    idle4();
    chk_id();
    $display("t_dis done");
  endtask : t_dis
  task automatic summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    bfm.tick(1'b1, 1'b0, b);
    w(8);
    rst = 1'b0;
    idle4();
    chk_id();
    t_byp();
    t_mbx();
    t_bp();
    t_bs();
    t_rst();
    t_dis();
    summarize();
  end
endmodule : jtag_debug_and_boundary_scan_tb_top
`default_nettype wire

// file: verif/jtdbg_checker.sv
// concurrent checks on the top-level ports
`timescale 1ns/10ps
`default_nettype none
module jtdbg_checker (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_DEBUG_ENABLE_FUSE,
  input wire logic I_LOCK_BIT_ONE,
  input wire logic I_LOCK_BIT_TWO,
  input wire logic I_CSR_WR,
  input wire logic I_CSR_DISABLE,
  input wire logic O_TEST_PORT_DISABLE_BIT,
  input wire logic I_MBX_WR,
  input wire logic [7:0] I_MBX_WDATA,
  input wire logic [7:0] O_MBX_RDATA,
  input wire logic O_MBX_SEL,
  input wire logic O_CPU_INSTR_STB,
  input wire logic O_BREAK,
  input wire logic I_EXT_RST_N,
  input wire logic O_CPU_RST,
  input wire logic [7:0] O_PIN_OE_N
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ======
  // mailbox
  sequence s_mbx_wr; I_MBX_WR && O_MBX_SEL; endsequence
  sequence s_dbg_off;
    !I_DEBUG_ENABLE_FUSE || I_LOCK_BIT_ONE || I_LOCK_BIT_TWO;
  endsequence
  property p_mbx_data;
    s_mbx_wr |=> O_MBX_RDATA == {1'b1, $past(I_MBX_WDATA[6:0])};
  endproperty
  a_mbx_data: assert property (p_mbx_data)
    else $error("mailbox readback wrong");
  property p_mbx_ign; !O_MBX_SEL |=> $stable(O_MBX_RDATA[6:0]); endproperty
  a_mbx_ign: assert property (p_mbx_ign)
    else $error("mailbox changed while deselected");
  property p_sel; !I_DEBUG_ENABLE_FUSE [*2] |-> !O_MBX_SEL; endproperty
  a_sel: assert property (p_sel)
    else $error("mailbox selected without fuse");
  // ======
  // debug gating and feed
  property p_dbg_off;
    s_dbg_off [*6] |-> !O_BREAK && !O_CPU_INSTR_STB;
  endproperty
  a_dbg_off: assert property (p_dbg_off)
    else $error("debug active while disabled");
  property p_stb; O_CPU_INSTR_STB |=> !O_CPU_INSTR_STB; endproperty
  a_stb: assert property (p_stb)
    else $error("instruction strobe too long");
  property p_dis;
    I_CSR_WR |-> ##3 O_TEST_PORT_DISABLE_BIT == $past(I_CSR_DISABLE, 3);
  endproperty
  a_dis: assert property (p_dis)
    else $error("disable bit not stored");
  // ======
  // reset
  property p_ext_rst; !I_EXT_RST_N [*5] |-> O_CPU_RST; endproperty
  a_ext_rst: assert property (p_ext_rst)
    else $error("pin reset ignored");
  property p_hiz; $rose(O_CPU_RST) |-> O_PIN_OE_N == 8'hff; endproperty
  a_hiz: assert property (p_hiz)
    else $error("pins driven in reset");
endmodule : jtdbg_checker
bind jtdbg_top jtdbg_checker u_chk (.I_REF_CLK, .I_SYS_RST,
  .I_DEBUG_ENABLE_FUSE, .I_LOCK_BIT_ONE, .I_LOCK_BIT_TWO, .I_CSR_WR,
  .I_CSR_DISABLE, .O_TEST_PORT_DISABLE_BIT, .I_MBX_WR, .I_MBX_WDATA,
  .O_MBX_RDATA, .O_MBX_SEL, .O_CPU_INSTR_STB, .O_BREAK, .I_EXT_RST_N,
  .O_CPU_RST, .O_PIN_OE_N);
`default_nettype wire

// file: verif/jtdbg_jtag_bfm.sv
// jtag controller model, tck still between frames
`timescale 1ns/10ps
`default_nettype none
module jtdbg_jtag_bfm (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe_n
);
  logic tdo_w;
  // released tdo reads high through the pull-up
  assign tdo_w = i_tdo_oe_n ? 1'b1 : i_tdo;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one tck period, tdo taken at the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #40 o_tck = 1'b1;
    tdo = tdo_w;
    #40 o_tck = 1'b0;
  endtask : tick
  // scan n bits from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    tick(1'b0, 1'b0, b);
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask : scan
endmodule : jtdbg_jtag_bfm
`default_nettype wire
